// ==== design/mic_params.svh ====
// Purpose: constants of the interrupt controller
// Assumes: apb byte addresses, 32-bit data, 8-bit registers
// Notes: include once
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH
`define MIC_OFF_IRQ_ENABLE 12'h000
`define MIC_OFF_IRQ_FLAG 12'h004
`define MIC_OFF_PIN_SELECT 12'h008
`define MIC_OFF_PWM_CONTROL 12'h00c
`define MIC_OFF_MODE 12'h010
`define MIC_OFF_CORE_STATUS 12'h014
`define MIC_OFF_WAKE_MASK 12'h018
`define MIC_OFF_WAKE_STATUS 12'h01c
`define MIC_BIT_T1 0
`define MIC_BIT_T2 1
`define MIC_BIT_T3 2
`define MIC_BIT_PB 5
`define MIC_BIT_ADC 6
`define MIC_BIT_GLOBAL 7
`define MIC_FLAG_MASK 8'h67
`define MIC_VECTOR 10'h3fe
`define MIC_STARTUP_NS 1000
`define MIC_CLK_MHZ 40
`define MIC_STARTUP_CYC ((`MIC_STARTUP_NS * `MIC_CLK_MHZ + 999) / 1000)
`endif

// ==== design/mic_pkg.sv ====
// Purpose: types of the interrupt controller
// Assumes: mic_params.svh holds the numbers
// Notes: none
package mic_pkg;
   typedef enum logic [1:0] {
      MIC_RUN = 2'b00,
      MIC_SLEEP = 2'b01,
      MIC_START = 2'b10
   } mic_state_t;
   typedef struct packed {
      logic t1_underflow;
      logic t1_pwm_period_end;
      logic t2_underflow;
      logic t3_underflow;
      logic adc_done;
   } mic_events_t;
   typedef struct packed {
      logic t1_pwm_mode;
      logic t2_pwm_duty;
   } mic_mode_t;
   typedef struct packed {
      mic_state_t state;
      logic [7:0] irq_enable_reg;
      logic [7:0] irq_flag_reg;
      logic [7:0] pin_change_select_reg;
      logic [7:0] pwm_control_reg;
      mic_mode_t mode;
      logic [7:0] pb_last;
      logic [3:0] pwm_div;
      logic [15:0] start_cnt;
      logic wake_stat;
      logic wake_mask;
      logic vector_req;
      logic clk_run;
      logic irq;
      logic [31:0] prdata;
      logic pready;
   } mic_reg_t;
endpackage

// ==== design/mic_ctrl.sv ====
// Function
// - takes pin-change, three timer, adc requests
// - flags set regardless of enable bits
// - bit 7 global enable gates all flag requests, not the wake vector or wake irq
// - source enables written independent of global
// - accepted request clears global, vectors 3fe
// - return instruction sets global enable again
// - selected pin change raises flag bit 5
// - sleep pin change restarts clock, vectors after startup
// - timer one underflow sets flag 0
// - pwm period ends divided by rate field plus one
// - timer two underflow sets flag 1
// - timer two pwm duty mode gives none
// - timer three underflow sets flag 2
// - adc done sets flag 6, software clears
// - enable bit 6 masks adc request
// Purpose: interrupt flags, masking, vectoring and wake of a small mcu
// Assumes: event inputs are one-cycle pulses synchronous to pclk
// Notes: apb slave, zero wait states, unmapped reads zero with pslverr
`timescale 1ns/1ps
`default_nettype none
`include "mic_params.svh"
module mic_ctrl
   import mic_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] port_b_pins,
   input wire mic_events_t events,
   input wire logic return_from_irq_instruction,
   input wire logic sleep_request,
   output logic vector_req,
   output logic [9:0] vector_addr,
   output logic core_clk_run,
   output logic irq
);
   mic_reg_t r_r;
   mic_reg_t r_nxt;
   logic wr;
   logic rd;
   logic pslverr_r;
   logic pslverr_nxt;
   logic [7:0] pb_change;
   logic [7:0] set_flags;
   logic accept;
   logic [31:0] rdata;
   logic mapped;

   always_comb
   begin
      wr = psel && !penable && pwrite;
      rd = psel && !penable && !pwrite;
      // pin changes only count for pins picked by the select register
      pb_change = (port_b_pins ^ r_r.pb_last) & r_r.pin_change_select_reg;
      set_flags = 8'h00;
      set_flags[`MIC_BIT_PB] = |pb_change;
      // timer one flag from underflow or divided pwm period
      set_flags[`MIC_BIT_T1] = r_r.mode.t1_pwm_mode ?
         (events.t1_pwm_period_end && r_r.pwm_div == 4'h0) :
         events.t1_underflow;
      set_flags[`MIC_BIT_T2] = events.t2_underflow &&
         !r_r.mode.t2_pwm_duty;
      set_flags[`MIC_BIT_T3] = events.t3_underflow;
      set_flags[`MIC_BIT_ADC] = events.adc_done;
      mapped = 1'b1;
      case (paddr)
         `MIC_OFF_IRQ_ENABLE: rdata = {24'h000000, r_r.irq_enable_reg};
         `MIC_OFF_IRQ_FLAG: rdata = {24'h000000, r_r.irq_flag_reg};
         `MIC_OFF_PIN_SELECT: rdata = {24'h000000,
            r_r.pin_change_select_reg};
         `MIC_OFF_PWM_CONTROL: rdata = {24'h000000, r_r.pwm_control_reg};
         `MIC_OFF_MODE: rdata = {30'h00000000, r_r.mode};
         `MIC_OFF_CORE_STATUS: rdata = {29'h00000000, r_r.clk_run,
            r_r.state};
         `MIC_OFF_WAKE_MASK: rdata = {31'h00000000, r_r.wake_mask};
         `MIC_OFF_WAKE_STATUS: rdata = {31'h00000000, r_r.wake_stat};
         default:
         begin
            rdata = 32'h00000000;
            mapped = 1'b0;
         end
      endcase
      r_nxt = r_r;
      pslverr_nxt = 1'b0;
      r_nxt.pready = psel && !penable;
      r_nxt.pb_last = port_b_pins;
      r_nxt.vector_req = 1'b0;
      if (r_r.mode.t1_pwm_mode && events.t1_pwm_period_end)
      begin
         r_nxt.pwm_div = (r_r.pwm_div == 4'h0) ?
            r_r.pwm_control_reg[3:0] : r_r.pwm_div - 4'h1;
      end
      if (rd)
      begin
         r_nxt.prdata = rdata;
         pslverr_nxt = !mapped;
      end
      if (wr)
      begin
         pslverr_nxt = !mapped;
         case (paddr)
            `MIC_OFF_IRQ_ENABLE: r_nxt.irq_enable_reg = pwdata[7:0];
            // writing zero clears a flag, one keeps it
            `MIC_OFF_IRQ_FLAG: r_nxt.irq_flag_reg =
               r_r.irq_flag_reg & pwdata[7:0] & `MIC_FLAG_MASK;
            `MIC_OFF_PIN_SELECT: r_nxt.pin_change_select_reg = pwdata[7:0];
            `MIC_OFF_PWM_CONTROL:
            begin
               r_nxt.pwm_control_reg = pwdata[7:0];
               r_nxt.pwm_div = pwdata[3:0];
            end
            `MIC_OFF_MODE: r_nxt.mode = pwdata[1:0];
            `MIC_OFF_WAKE_MASK: r_nxt.wake_mask = pwdata[0];
            default: ;
         endcase
      end
      if (rd && paddr == `MIC_OFF_WAKE_STATUS)
      begin
         r_nxt.wake_stat = 1'b0;
      end
      // set beats a same-cycle software clear
      r_nxt.irq_flag_reg = r_nxt.irq_flag_reg | set_flags;
      if (return_from_irq_instruction)
      begin
         r_nxt.irq_enable_reg[`MIC_BIT_GLOBAL] = 1'b1;
      end
      accept = 1'b0;
      case (r_r.state)
         MIC_RUN:
         begin
            accept = r_r.irq_enable_reg[`MIC_BIT_GLOBAL] &&
               |(r_r.irq_flag_reg & r_r.irq_enable_reg &
               `MIC_FLAG_MASK);
            if (sleep_request && !accept)
            begin
               r_nxt.state = MIC_SLEEP;
               r_nxt.clk_run = 1'b0;
            end
         end
         MIC_SLEEP:
         begin
            // any selected pin change wakes, even with enables clear
            if (|pb_change)
            begin
               r_nxt.state = MIC_START;
               r_nxt.clk_run = 1'b1;
               r_nxt.start_cnt = 16'(`MIC_STARTUP_CYC);
               r_nxt.wake_stat = 1'b1;
            end
         end
         MIC_START:
         begin
            if (r_r.start_cnt <= 16'h0001)
            begin
               r_nxt.state = MIC_RUN;
               r_nxt.vector_req = 1'b1;
               r_nxt.irq_enable_reg[`MIC_BIT_GLOBAL] = 1'b0;
            end
            else
            begin
               r_nxt.start_cnt = r_r.start_cnt - 16'h0001;
            end
         end
         default: r_nxt.state = MIC_RUN;
      endcase
      if (accept)
      begin
         r_nxt.irq_enable_reg[`MIC_BIT_GLOBAL] = 1'b0;
         r_nxt.vector_req = 1'b1;
      end
      // interrupt line, level: wake status under wake mask (cleared by reading) or enabled flag under global in run
      r_nxt.irq = (r_nxt.wake_stat && r_nxt.wake_mask) ||
         (r_nxt.state == MIC_RUN && r_nxt.irq_enable_reg[`MIC_BIT_GLOBAL]
         && |(r_nxt.irq_flag_reg & r_nxt.irq_enable_reg & `MIC_FLAG_MASK));
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_r <= '{state: MIC_RUN, clk_run: 1'b1, default: '0};
         pslverr_r <= 1'b0;
      end
      else
      begin
         r_r <= r_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata = r_r.prdata;
   assign pready = r_r.pready;
   assign pslverr = pslverr_r;
   assign vector_req = r_r.vector_req;
   assign vector_addr = `MIC_VECTOR;
   assign core_clk_run = r_r.clk_run;
   assign irq = r_r.irq;
endmodule
`default_nettype wire

// ==== sim/mic_partner.sv ====
// Purpose: stand-in for timers, adc and port b
// Assumes: fire and toggle held one cycle by the bench
// Notes: events leave as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module mic_partner
   import mic_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [4:0] fire,
   input wire logic [7:0] toggle,
   output mic_events_t events,
   output logic [7:0] port_b_pins
);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         events <= '0;
         port_b_pins <= 8'h00;
      end
      else
      begin
         events <= mic_events_t'(fire);
         port_b_pins <= port_b_pins ^ toggle;
      end
   end
endmodule
`default_nettype wire

// ==== sim/mic_ctrl_assertions.sv ====
// Purpose: port checks of mic_ctrl
// Assumes: apb answer one cycle after setup
// Notes: bound to every mic_ctrl
`timescale 1ns/1ps
`default_nettype none
module mic_ctrl_assertions
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sleep_request,
   input wire logic vector_req,
   input wire logic [9:0] vector_addr,
   input wire logic core_clk_run
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_setup_gets_ready: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready too long");
   a_refusal_with_ready: assert property (pslverr |-> pready)
      else $error("refusal without pready");
   // prdata keeps the last read on a refused write, so only reads count
   a_refusal_reads_zero: assert property (pslverr && !$past(pwrite) |->
      prdata == 32'h00000000)
      else $error("refused read not zero");
   a_vector_fixed: assert property (vector_addr == 10'h3fe)
      else $error("vector address wrong");
   a_vector_pulse: assert property (vector_req |=> !vector_req)
      else $error("vector pulse too long");
   a_vector_clock_runs: assert property (vector_req |-> core_clk_run)
      else $error("vector while asleep");
   a_sleep_stops_clock: assert property ($fell(core_clk_run) |->
      $past(sleep_request) || $past(sleep_request, 2))
      else $error("clock stopped unasked");
   a_wake_then_vector: assert property ($rose(core_clk_run) |->
      ##[0:60] vector_req)
      else $error("no vector after wake");
   cover property (vector_req);
   cover property (pslverr);
   cover property ($rose(core_clk_run));
endmodule
bind mic_ctrl mic_ctrl_assertions mic_ctrl_assertions_i (.*);
`default_nettype wire

// ==== sim/mcu_interrupt_controller_bench.sv ====
// Purpose: self-checking bench of mic_ctrl
// Assumes: flags cleared by writing 0, wake after startup count
// Notes: sleep entry judged after a short settle
`timescale 1ns/1ps
`default_nettype none
module mcu_interrupt_controller_bench;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic return_from_irq_instruction = 1'b0;
   logic sleep_request = 1'b0;
   logic [4:0] fire = 5'h00;
   logic [7:0] toggle = 8'h00;
   logic [31:0] prdata, q;
   logic pready, pslverr, vector_req, core_clk_run, irq, perr;
   logic [9:0] vector_addr;
   logic [7:0] port_b_pins;
   mic_pkg::mic_events_t events;
   int err_total = 0;
   int n_tests = 0;
   int nvec = 0;
   int cyc = 0;
   mic_ctrl mic_ctrl_i (.*);
   mic_partner mic_partner_i (.*);
   initial
   begin
      forever #12.5 pclk = ~pclk;
   end
   task automatic print_verdict();
      $display("tests %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (vector_req === 1'b1)
         nvec <= nvec + 1;
      if (cyc == 3000)
      begin
         err_total = err_total + 1;
         print_verdict();
      end
   end
   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      n_tests = n_tests + 1;
      if (s !== e)
      begin
         err_total = err_total + 1;
         $display("MISMATCH %s exp %h seen %h", nm, e, s);
      end
   endtask
   // one edge after release keeps psel from two writes in a step
   task automatic wr(logic [11:0] a, logic [31:0] d, logic w = 1'b1);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(string nm, logic [11:0] a, logic [31:0] e);
      wr(a, 32'h0, 1'b0);
      chk(nm, q, e);
   endtask
   task automatic ev(logic [4:0] f, logic [7:0] t, logic r, logic s);
      fire <= f;
      toggle <= t;
      return_from_irq_instruction <= r;
      sleep_request <= s;
      @(posedge pclk);
      fire <= 5'h00;
      toggle <= 8'h00;
      return_from_irq_instruction <= 1'b0;
      sleep_request <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd("en", 'h0, 'h0);
      ev(5'h02, 'h0, 0, 0);
      rd("t3", 'h4, 'h4);
      chk("irq", {31'h0, irq}, 'h0);
      wr('h4, 'hfb);
      wr('h0, 'h41);
      rd("src en", 'h0, 'h41);
      ev(5'h01, 'h0, 0, 0);
      chk("no glob", {31'h0, irq}, 'h0);
      rd("adc", 'h4, 'h40);
      wr('h4, 'h0);
      wr('h0, 'hc1);
      ev(5'h10, 'h0, 0, 0);
      chk("vec", nvec, 1);
      rd("glob off", 'h0, 'h41);
      wr('h4, 'h0);
      ev(5'h00, 'h0, 1, 0);
      rd("glob on", 'h0, 'hc1);
      wr('h0, 'h0);
      wr('h10, 'h1);
      ev(5'h04, 'h0, 0, 0);
      rd("duty", 'h4, 'h0);
      wr('h10, 'h2);
      wr('hc, 'h1);
      ev(5'h04, 'h0, 0, 0);
      ev(5'h08, 'h0, 0, 0);
      rd("rate", 'h4, 'h2);
      ev(5'h08, 'h0, 0, 0);
      rd("rate2", 'h4, 'h3);
      wr('h4, 'h0);
      wr('h8, 'h1);
      wr('h0, 'ha0);
      ev(5'h00, 'h2, 0, 0);
      rd("unsel", 'h4, 'h0);
      ev(5'h00, 'h1, 0, 0);
      chk("pin vec", nvec, 2);
      rd("pin", 'h4, 'h20);
      wr('h4, 'hdf);
      ev(5'h00, 'h0, 0, 1);
      chk("sleep", {31'h0, core_clk_run}, 'h0);
      ev(5'h00, 'h1, 0, 0);
      for (int i = 0; i < 100 && nvec == 2; i++)
         @(posedge pclk);
      chk("wake", nvec, 3);
      chk("run", {31'h0, core_clk_run}, 'h1);
      rd("unmap", 'h20, 'h0);
      chk("slverr", {31'h0, perr}, 'h1);
      wr('h18, 'h1);
      chk("wake irq", {31'h0, irq}, 'h1);
      rd("wake st", 'h1c, 'h1);
      chk("irq off", {31'h0, irq}, 'h0);
      print_verdict();
   end
endmodule
`default_nettype wire
